// ### core/rtcsr_top.sv
// Behaviour
// - low_voltage_one_flag, status bit 2, sets while supply is below threshold one.
// - writing one to reset_control bit 4 starts a system reset of the logic.
// - trigger bit at zero never causes a system reset.
// - after the logic restarts, trigger bit clears to zero by itself.
// - a finished triggered reset sets recovery_reset_flag, status bit 4.
// - unimplemented bits of status and reset_control read as zero.
module rtcsr_top (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic i_below_threshold_one,
   input wire logic i_below_threshold_two,
   input wire logic i_eeprom_busy,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   output logic o_soft_reset,
   output logic o_irq
);
   typedef struct packed {
      rtcsr_pkg::rtcsr_state_t fsm;
      logic [7:0] count;
      logic [7:0] status;
      logic trigger;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic soft_reset;
      logic irq;
   } rtcsr_top_state_t;

   rtcsr_top_state_t state;
   rtcsr_top_state_t next_state;
   logic [2:0] pins_sync;
   logic setup;
   logic wr;
   logic [7:0] wbyte;
   logic [3:0] events;

   function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
      hit = addr == target;
   endfunction : hit

   // pins come from the analog and eeprom domains
   rtcsr_sync #(
      .WIDTH(3)
   ) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_eeprom_busy, i_below_threshold_two, i_below_threshold_one}),
      .o_sync(pins_sync)
   );

   assign setup = i_psel && !i_penable;
   assign wr = i_psel && i_penable && state.pready && i_pwrite;
   assign wbyte = i_pwdata[7:0];

   always_comb begin
      next_state = state;
      events = 4'h0;
      next_state.pready = 1'b0;
      next_state.pslverr = 1'b0;
      next_state.status[rtcsr_pkg::bit_eeprom_busy] = pins_sync[2];
      // flags are sticky so a brief dip is still seen by the host
      if (pins_sync[0]) begin
         next_state.status[rtcsr_pkg::bit_low_one] = 1'b1;
         events[rtcsr_pkg::irq_bit_low_one] = 1'b1;
      end
      if (pins_sync[1]) begin
         next_state.status[rtcsr_pkg::bit_low_two] = 1'b1;
         events[rtcsr_pkg::irq_bit_low_two] = 1'b1;
      end
      // no-wait-state slave: ready in the first access cycle
      if (setup) begin
         next_state.pready = 1'b1;
         next_state.pslverr = !(hit(i_paddr, rtcsr_pkg::addr_device_status)
            || hit(i_paddr, rtcsr_pkg::addr_reset_control)
            || hit(i_paddr, rtcsr_pkg::addr_irq_status)
            || hit(i_paddr, rtcsr_pkg::addr_irq_mask));
         next_state.prdata = 32'h0000_0000;
         if (hit(i_paddr, rtcsr_pkg::addr_device_status)) begin
            next_state.prdata = {24'h00_0000, state.status & rtcsr_pkg::status_impl_mask};
         end
         if (hit(i_paddr, rtcsr_pkg::addr_reset_control)) begin
            next_state.prdata = {24'h00_0000, {3'h0, state.trigger, 4'h0}};
         end
         if (hit(i_paddr, rtcsr_pkg::addr_irq_status)) begin
            next_state.prdata = {28'h000_0000, state.irq_status};
         end
         if (hit(i_paddr, rtcsr_pkg::addr_irq_mask)) begin
            next_state.prdata = {28'h000_0000, state.irq_mask};
         end
      end
      if (wr && hit(i_paddr, rtcsr_pkg::addr_device_status)) begin
         // writing zero clears a flag, a low-voltage flag only once its input is inactive; a one leaves it alone
         if (!wbyte[rtcsr_pkg::bit_power_on]) begin
            next_state.status[rtcsr_pkg::bit_power_on] = 1'b0;
         end
         if (!wbyte[rtcsr_pkg::bit_recovery]) begin
            next_state.status[rtcsr_pkg::bit_recovery] = 1'b0;
         end
         if (!wbyte[rtcsr_pkg::bit_low_two] && !pins_sync[1]) begin
            next_state.status[rtcsr_pkg::bit_low_two] = 1'b0;
         end
         if (!wbyte[rtcsr_pkg::bit_low_one] && !pins_sync[0]) begin
            next_state.status[rtcsr_pkg::bit_low_one] = 1'b0;
         end
      end
      if (wr && hit(i_paddr, rtcsr_pkg::addr_irq_mask)) begin
         next_state.irq_mask = wbyte[3:0] & rtcsr_pkg::irq_impl_mask;
      end
      case (state.fsm)
         rtcsr_pkg::rtcsr_run: begin
            if (wr && hit(i_paddr, rtcsr_pkg::addr_reset_control) && wbyte[rtcsr_pkg::bit_sys_trigger]) begin
               next_state.trigger = 1'b1;
               next_state.fsm = rtcsr_pkg::rtcsr_resetting;
               next_state.count = rtcsr_pkg::soft_reset_cycles;
               next_state.soft_reset = 1'b1;
            end
         end
         rtcsr_pkg::rtcsr_resetting: begin
            // the soft reset spares this bank so the flags survive
            if (state.count == 8'h01) begin
               next_state.fsm = rtcsr_pkg::rtcsr_restarted;
               next_state.soft_reset = 1'b0;
            end
            next_state.count = state.count - 8'h01;
         end
         rtcsr_pkg::rtcsr_restarted: begin
            next_state.trigger = 1'b0;
            next_state.status[rtcsr_pkg::bit_recovery] = 1'b1;
            events[rtcsr_pkg::irq_bit_recovery] = 1'b1;
            next_state.fsm = rtcsr_pkg::rtcsr_run;
         end
         default: begin
            next_state.fsm = rtcsr_pkg::rtcsr_run;
            next_state.soft_reset = 1'b0;
         end
      endcase
      if (wr && hit(i_paddr, rtcsr_pkg::addr_irq_status)) begin
         next_state.irq_status = state.irq_status & ~wbyte[3:0];
      end
      // set wins over a simultaneous clear
      next_state.irq_status = next_state.irq_status | events;
      next_state.irq = |(next_state.irq_status & next_state.irq_mask);
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= '0;
         state.fsm <= rtcsr_pkg::rtcsr_run;
         state.status <= rtcsr_pkg::status_reset_value;
         state.irq_status <= rtcsr_pkg::irq_status_reset_value;
         state.irq_mask <= rtcsr_pkg::irq_mask_reset_value;
      end else begin
         state <= next_state;
      end
   end

   assign o_pready = state.pready;
   assign o_pslverr = state.pslverr;
   assign o_prdata = state.prdata;
   assign o_soft_reset = state.soft_reset;
   assign o_irq = state.irq;
endmodule : rtcsr_top

// ### core/rtcsr_pkg.sv
package rtcsr_pkg;
   localparam logic [31:0] addr_device_status = 32'h0000_0003 * 32'h0000_0004;
   localparam logic [31:0] addr_reset_control = 32'h0000_0004 * 32'h0000_0004;
   localparam logic [31:0] addr_irq_status = 32'h0000_0020;
   localparam logic [31:0] addr_irq_mask = 32'h0000_0024;
   localparam int bit_eeprom_busy = 7;
   localparam int bit_power_on = 5;
   localparam int bit_recovery = 4;
   localparam int bit_low_two = 3;
   localparam int bit_low_one = 2;
   localparam int bit_sys_trigger = 4;
   localparam logic [7:0] status_impl_mask = 8'hbc;
   localparam logic [7:0] reset_impl_mask = 8'h10;
   localparam logic [3:0] irq_impl_mask = 4'hf;
   localparam logic [7:0] status_reset_value = 8'h20;
   localparam logic [3:0] irq_mask_reset_value = 4'h0;
   localparam logic [3:0] irq_status_reset_value = 4'h8;
   localparam int soft_reset_ns = 200;
   localparam int clk_period_ns = 40;
   localparam logic [7:0] soft_reset_cycles = 8'((soft_reset_ns + clk_period_ns - 1) / clk_period_ns);
   localparam int irq_bit_low_one = 0;
   localparam int irq_bit_low_two = 1;
   localparam int irq_bit_recovery = 2;
   localparam int irq_bit_power_on = 3;
   typedef enum logic [1:0] {
      rtcsr_run = 2'b00,
      rtcsr_resetting = 2'b01,
      rtcsr_restarted = 2'b11
   } rtcsr_state_t;
endpackage : rtcsr_pkg

// ### core/rtcsr_sync.sv
module rtcsr_sync #(
   parameter int WIDTH = 3
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } rtcsr_sync_state_t;
   rtcsr_sync_state_t state;
   rtcsr_sync_state_t next_state;
   always_comb begin
      next_state.stage1 = i_async;
      next_state.stage2 = state.stage1;
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign o_sync = state.stage2;
endmodule : rtcsr_sync

// ### sim/rtcsr_checker.sv
module rtcsr_checker (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic i_below_threshold_one,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [31:0] o_prdata,
   input wire logic o_soft_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic rd = o_pready && !i_pwrite;
   wire logic trig = i_psel && i_penable && o_pready && i_pwrite && i_paddr == 32'h10 && i_pwdata[4];
   a_ready_one_cycle: assert property (i_psel && !i_penable |=> o_pready)
      else $error("ready late");
   a_low_one_seen: assert property (rd && i_paddr == 32'hc && $past(i_below_threshold_one, 4) |-> o_prdata[2])
      else $error("low flag missing");
   a_trigger_pulse: assert property (trig && !o_soft_reset |=> o_soft_reset[*5] ##1 !o_soft_reset)
      else $error("reset pulse wrong");
   a_no_spurious: assert property ($rose(o_soft_reset) |-> $past(trig))
      else $error("reset without trigger");
   a_trigger_clears: assert property (rd && i_paddr == 32'h10 && !o_soft_reset && $past(!o_soft_reset) |-> o_prdata == 0)
      else $error("trigger stuck");
   a_status_unused: assert property (rd && i_paddr == 32'hc |-> (o_prdata & ~32'(rtcsr_pkg::status_impl_mask)) == 0)
      else $error("status spare bits");
   a_reset_unused: assert property (rd && i_paddr == 32'h10 |-> (o_prdata & 32'hffff_ffef) == 0)
      else $error("reset spare bits");
   c_trigger: cover property (trig);
   c_reset_done: cover property ($fell(o_soft_reset));
   c_slave_error: cover property (o_pready && o_pslverr);
endmodule : rtcsr_checker
bind rtcsr_top rtcsr_checker rtcsr_checker_inst (.*);

// ### sim/rtcsr_supply_model.sv
module rtcsr_supply_model (
   input wire logic i_clk,
   input wire logic [2:0] i_cmd,
   output logic o_below_one,
   output logic o_below_two,
   output logic o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] lvl = 3'h0;
   // edge-aligned levels; real comparators are async but the block syncs them
   always_ff @(posedge i_clk) lvl <= i_cmd;
   assign {o_busy, o_below_two, o_below_one} = lvl;
endmodule : rtcsr_supply_model

// ### sim/rtc_status_and_soft_reset_tb_top.sv
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module rtc_status_and_soft_reset_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [31:0] i_paddr = 0, i_pwdata = 0, o_prdata, rnd = 32'h880b;
   logic i_below_threshold_one, i_below_threshold_two, i_eeprom_busy, o_pready, o_pslverr, o_soft_reset, o_irq;
   logic [2:0] cmd = 0;
   logic [32:0] exp_q[$], got;
   int fails = 0, compares = 0, cycles = 0;
   rtcsr_top rtcsr_top_inst (.*);
   rtcsr_supply_model rtcsr_supply_model_inst (.i_clk(i_clk), .i_cmd(cmd), .o_below_one(i_below_threshold_one),
      .o_below_two(i_below_threshold_two), .o_busy(i_eeprom_busy));
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic complete_run;
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // reads note their expectation; the monitor below compares on pready
   task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e = 0);
      @(posedge i_clk);
      if (!w) exp_q.push_back(e);
      i_psel <= 1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      i_psel <= 0;
      i_penable <= 0;
   endtask : apb
   always @(posedge i_clk) begin
      cycles++;
      if (cycles > 3000) begin
         fails++;
         complete_run();
      end else if (o_pready && !i_pwrite && exp_q.size() > 0) begin
         got = exp_q.pop_front();
         `CHK({o_pslverr, o_prdata}, got)
      end
   end
   initial begin
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 0;
      apb(0, 32'hc, 0, 33'h20);
      apb(0, 32'h10, 0, 33'h0);
      apb(1, 32'hc, 32'h0);
      apb(0, 32'hc, 0, 33'h0);
      apb(0, 32'h40, 0, 33'h1_0000_0000);
      apb(0, 32'h20, 0, 33'h8);
      apb(1, 32'h24, 32'hf);
      repeat (2) @(posedge i_clk);
      `CHK(o_irq, 1'b1)
      apb(1, 32'h20, 32'hf);
      repeat (2) @(posedge i_clk);
      `CHK(o_irq, 1'b0)
      cmd <= 3'b111;
      repeat (8) @(posedge i_clk);
      apb(0, 32'hc, 0, 33'h8c);
      `CHK(o_irq, 1'b1)
      cmd <= 3'b000;
      repeat (4) @(posedge i_clk);
      apb(1, 32'hc, {rnd[31:8], 8'h00});
      apb(1, 32'h20, 32'hf);
      apb(0, 32'hc, 0, 33'h0);
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         apb(1, 32'h10, rnd & 32'hffff_ffef);
         apb(0, 32'h10, 0, 33'h0);
         `CHK(o_soft_reset, 1'b0)
      end
      apb(1, 32'h10, 32'h10);
      apb(0, 32'h10, 0, 33'h10);
      `CHK(o_soft_reset, 1'b1)
      repeat (8) @(posedge i_clk);
      apb(0, 32'h10, 0, 33'h0);
      `CHK(o_soft_reset, 1'b0)
      apb(0, 32'hc, 0, 33'h10);
      apb(0, 32'h20, 0, 33'h4);
      `CHK(o_irq, 1'b1)
      repeat (2) @(posedge i_clk);
      complete_run();
   end
endmodule : rtc_status_and_soft_reset_tb_top
